/* File: verilog/tcu_pkg.sv */
// constants, field layout and helpers for the upper 16-bit timer control block
// assumes apb with 32-bit data and a 12-bit byte address; one clock, pclk
//
// Notes on behaviour
// - with stop in idle set the timer halts during idle mode, with it clear it keeps running.
// - with the external pin as source the gated accumulate bit has no effect at all.
// - with the internal clock, gated accumulate 1 counts only while the gate pin is high, 0 never gates.
// - prescale field 11 divides by 256, 10 by 64, 01 by 8 and 00 passes every input tick.
// - clock source select 1 takes ticks from the external clock pin, 0 from the internal clock.
// - the external source counts on each rising edge of the external clock pin.
// - the unimplemented bits 14, 12 to 7, 3 to 2 and 0 of the control register read as 0.
// - while paired wide mode is on, run, gate, prescale and source controls of this timer are ignored.

package tcu_pkg;

  localparam int          TCU_ADDR_W      = 12;

  // byte addresses of the registers
  localparam logic [11:0] TCU_CTRL_OFFSET  = 12'h000;
  localparam logic [11:0] TCU_COUNT_OFFSET = 12'h004;
  localparam logic [11:0] TCU_STAT_OFFSET  = 12'h008;

  // control register fields
  localparam int          TCU_RUN_BIT     = 15;
  localparam int          TCU_IDLE_BIT    = 13;
  localparam int          TCU_GATE_BIT    = 6;
  localparam int          TCU_PS_LSB      = 4;
  localparam int          TCU_PS_MSB      = 5;
  localparam int          TCU_SRC_BIT     = 1;
  localparam logic [15:0] TCU_CTRL_MASK   = 16'hA072;
  localparam logic [15:0] TCU_CTRL_RESET  = 16'h0000;
  localparam logic [15:0] TCU_COUNT_RESET = 16'h0000;

  // status register fields
  localparam int          TCU_ST_RUN_BIT    = 0;
  localparam int          TCU_ST_PIN_BIT    = 1;
  localparam int          TCU_ST_PAIR_BIT   = 2;
  localparam int          TCU_ST_GATED_BIT  = 3;
  localparam int          TCU_ST_EXT_BIT    = 4;
  localparam int          TCU_ST_PHASE_LSB  = 8;
  localparam int          TCU_ST_PHASE_MSB  = 15;

  // prescale codes and terminal counts of the divider
  localparam logic [1:0]  TCU_PS_DIV1     = 2'b00;
  localparam logic [1:0]  TCU_PS_DIV8     = 2'b01;
  localparam logic [1:0]  TCU_PS_DIV64    = 2'b10;
  localparam logic [1:0]  TCU_PS_DIV256   = 2'b11;
  localparam logic [7:0]  TCU_TERM_DIV1   = 8'h00;
  localparam logic [7:0]  TCU_TERM_DIV8   = 8'h07;
  localparam logic [7:0]  TCU_TERM_DIV64  = 8'h3F;
  localparam logic [7:0]  TCU_TERM_DIV256 = 8'hFF;

  // pin synchroniser depth
  localparam int          TCU_SYNC_STAGES = 3;

  typedef enum logic [1:0] {
    TCU_SRC_FREE,
    TCU_SRC_GATED,
    TCU_SRC_PIN_EDGE
  } tcu_src_t;

  // last input tick count before the divider fires
  function automatic logic [7:0] tcu_prescale_terminal(input logic [1:0] sel);
    logic [7:0] term;
    term = TCU_TERM_DIV1;
    unique case (sel)
      TCU_PS_DIV1:   term = TCU_TERM_DIV1;
      TCU_PS_DIV8:   term = TCU_TERM_DIV8;
      TCU_PS_DIV64:  term = TCU_TERM_DIV64;
      TCU_PS_DIV256: term = TCU_TERM_DIV256;
    endcase
    return term;
  endfunction

  function automatic logic tcu_addr_known(input logic [11:0] addr);
    return (addr == TCU_CTRL_OFFSET) || (addr == TCU_COUNT_OFFSET) ||
           (addr == TCU_STAT_OFFSET);
  endfunction

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] tcu_merge16(input logic [15:0] old,
                                              input logic [31:0] wdata,
                                              input logic [3:0]  strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = wdata[7:0];
    end
    if (strb[1]) begin
      res[15:8] = wdata[15:8];
    end
    return res;
  endfunction

endpackage

/* File: verilog/tcu_pin_sync.sv */
// three-stage synchroniser for the external clock pin
// assumes the pin is asynchronous to pclk; a change counts once stages two and three agree
`timescale 1ns/10ps
`default_nettype none

module tcu_pin_sync
  import tcu_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin,
  output logic      level,
  output logic      rise
);

  typedef struct packed {
    logic [TCU_SYNC_STAGES-1:0] stage;
    logic                       level;
    logic                       rise;
  } tcu_sync_t;

  tcu_sync_t st;
  tcu_sync_t next_st;

  always_comb begin
    next_st = st;
    next_st.stage = {st.stage[TCU_SYNC_STAGES-2:0], pin};
    next_st.rise  = 1'b0;
    // only stages two and three are looked at, never the first
    if (st.stage[1] == st.stage[2]) begin
      next_st.level = st.stage[1];
      next_st.rise  = st.stage[1] & ~st.level;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level = st.level;
  assign rise  = st.rise;

endmodule

`default_nettype wire

/* File: verilog/tcu_prescaler.sv */
// input clock divider of 1, 8, 64 or 256 for the timer
// assumes tick_in is a one-cycle pulse on pclk; clear restarts the phase
`timescale 1ns/10ps
`default_nettype none

module tcu_prescaler
  import tcu_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       tick_in,
  input  wire logic       clear,
  input  wire logic [1:0] ratio_sel,
  output logic            tick_out,
  output logic [7:0]      phase
);

  typedef struct packed {
    logic [7:0] cnt;
    logic       out;
  } tcu_presc_t;

  tcu_presc_t st;
  tcu_presc_t next_st;

  always_comb begin
    next_st = st;
    next_st.out = 1'b0;
    if (clear) begin
      next_st.cnt = 8'h00;
    end else if (tick_in) begin
      if (st.cnt >= tcu_prescale_terminal(ratio_sel)) begin
        next_st.cnt = 8'h00;
        next_st.out = 1'b1;
      end else begin
        next_st.cnt = st.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick_out = st.out;
  assign phase    = st.cnt;

endmodule

`default_nettype wire

/* File: verilog/tcu_upper_timer.sv */
// upper 16-bit timer of a pair: control register, count and apb slave
// assumes idle_mode and paired_wide_mode come from logic on pclk;
// the external clock pin is asynchronous and is synchronised here
`timescale 1ns/10ps
`default_nettype none

module tcu_upper_timer
  import tcu_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        idle_mode,
  input  wire logic        paired_wide_mode,
  input  wire logic        upper_timer_ext_clock_pin,
  output logic [15:0]      count_value,
  output logic             timer_active
);

  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] count;
    logic [31:0] rdata;
    logic        err;
  } tcu_main_t;

  tcu_main_t st;
  tcu_main_t next_st;

  logic       pin_level;
  logic       pin_rise;
  logic       presc_tick;
  logic [7:0] presc_phase;

  logic       setup_phase;
  logic       access_phase;
  logic       addr_ok;
  logic       ctrl_wr;
  logic       count_wr;

  logic       run_enable;
  logic       stop_in_idle;
  logic       gated_accumulate_enable;
  logic [1:0] input_prescale_select;
  logic       clock_source_select;

  logic       controls_live;
  logic       idle_halt;
  logic       running;
  tcu_src_t   src_mode;
  logic       raw_tick;
  logic       presc_clear;
  logic [15:0] status_word;

  tcu_pin_sync u_pin_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin     (upper_timer_ext_clock_pin),
    .level   (pin_level),
    .rise    (pin_rise)
  );

  tcu_prescaler u_prescaler (
    .pclk      (pclk),
    .presetn   (presetn),
    .tick_in   (raw_tick),
    .clear     (presc_clear),
    .ratio_sel (input_prescale_select),
    .tick_out  (presc_tick),
    .phase     (presc_phase)
  );

  // bus phases and decode
  assign setup_phase  = psel & ~penable;
  assign access_phase = psel & penable;
  assign addr_ok      = tcu_addr_known(paddr);
  assign ctrl_wr      = access_phase & pwrite & (paddr == TCU_CTRL_OFFSET);
  assign count_wr     = access_phase & pwrite & (paddr == TCU_COUNT_OFFSET);

  // control fields
  assign run_enable              = st.ctrl[TCU_RUN_BIT];
  assign stop_in_idle            = st.ctrl[TCU_IDLE_BIT];
  assign gated_accumulate_enable = st.ctrl[TCU_GATE_BIT];
  assign input_prescale_select   = st.ctrl[TCU_PS_MSB:TCU_PS_LSB];
  assign clock_source_select     = st.ctrl[TCU_SRC_BIT];

  assign controls_live = ~paired_wide_mode;

  assign idle_halt = idle_mode & stop_in_idle;

  assign running = controls_live & run_enable & ~idle_halt;

  // source choice; external pin takes priority over gating
  always_comb begin
    src_mode = TCU_SRC_FREE;
    if (clock_source_select) begin
      src_mode = TCU_SRC_PIN_EDGE;
    end else if (gated_accumulate_enable) begin
      src_mode = TCU_SRC_GATED;
    end
  end

  always_comb begin
    raw_tick = 1'b0;
    if (running) begin
      unique case (src_mode)
        TCU_SRC_FREE:     raw_tick = 1'b1;
        TCU_SRC_GATED:    raw_tick = pin_level;
        TCU_SRC_PIN_EDGE: raw_tick = pin_rise;
      endcase
    end
  end

  // a stopped timer or a control rewrite restarts the divider phase
  assign presc_clear = ~running | ctrl_wr;

  always_comb begin
    status_word = 16'h0000;
    status_word[TCU_ST_RUN_BIT]   = running;
    status_word[TCU_ST_PIN_BIT]   = pin_level;
    status_word[TCU_ST_PAIR_BIT]  = paired_wide_mode;
    status_word[TCU_ST_GATED_BIT] = running & (src_mode == TCU_SRC_GATED);
    status_word[TCU_ST_EXT_BIT]   = running & (src_mode == TCU_SRC_PIN_EDGE);
    status_word[TCU_ST_PHASE_MSB:TCU_ST_PHASE_LSB] = presc_phase;
  end

  always_comb begin
    next_st = st;

    // read data is fetched in setup so prdata comes from a register
    if (setup_phase) begin
      next_st.err   = ~addr_ok;
      next_st.rdata = 32'h0000_0000;
      if (!pwrite) begin
        unique case (1'b1)
          (paddr == TCU_CTRL_OFFSET):  next_st.rdata = {16'h0000, st.ctrl & TCU_CTRL_MASK};
          (paddr == TCU_COUNT_OFFSET): next_st.rdata = {16'h0000, st.count};
          (paddr == TCU_STAT_OFFSET):  next_st.rdata = {16'h0000, status_word};
          default:                     next_st.rdata = 32'h0000_0000;
        endcase
      end
    end

    if (ctrl_wr) begin
      next_st.ctrl = tcu_merge16(st.ctrl, pwdata, pstrb) & TCU_CTRL_MASK;
    end

    if (count_wr) begin
      // a software load wins over a tick in the same cycle
      next_st.count = tcu_merge16(st.count, pwdata, pstrb);
    end else if (running && presc_tick) begin
      next_st.count = st.count + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st.ctrl  <= TCU_CTRL_RESET;
      st.count <= TCU_COUNT_RESET;
      st.rdata <= 32'h0000_0000;
      st.err   <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // zero wait state slave
  assign pready       = access_phase;
  assign pslverr      = access_phase & st.err;
  assign prdata       = st.rdata;
  assign count_value  = st.count;
  assign timer_active = running;

endmodule

`default_nettype wire

/* File: dv/tcu_checker.sv */
// port assertions for the upper timer control block
// bound to tcu_upper_timer; one clock pclk, async low reset
`timescale 1ns/10ps
`default_nettype none

module tcu_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        idle_mode,
  input wire logic        paired_wide_mode,
  input wire logic        upper_timer_ext_clock_pin,
  input wire logic [15:0] count_value,
  input wire logic        timer_active
);
  logic wr;
  // writes may move the count at any time
  assign wr = psel && penable && pwrite;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_count_frozen: assert property (
    (!timer_active && !wr) [*3] |=> $stable(count_value)) else $error("count moved while off");
  a_count_step: assert property (
    !wr |=> (count_value == $past(count_value)) || (count_value == $past(count_value) + 16'h0001))
    else $error("count jumped");
  a_pair_off: assert property (
    paired_wide_mode |-> !timer_active) else $error("active in paired mode");
  a_pair_hold: assert property (
    (paired_wide_mode && !wr) [*3] |=> $stable(count_value)) else $error("count moved paired");
  a_upper_zero: assert property (
    prdata[31:16] == 16'h0000) else $error("upper read bits set");
  a_err_data: assert property (
    pslverr && !pwrite |-> prdata == 32'h0000_0000) else $error("error read not zero");
  a_rdata_hold: assert property (
    !psel |=> $stable(prdata)) else $error("read data moved");
  a_ready_access: assert property (
    pready == (psel && penable)) else $error("pready outside access");
  a_err_access: assert property (
    pslverr |-> pready) else $error("error outside access");

  cover property (timer_active ##1 count_value != $past(count_value));
  cover property (pslverr);
  cover property (paired_wide_mode && wr);
endmodule

bind tcu_upper_timer tcu_checker i_tcu_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .idle_mode(idle_mode),
  .paired_wide_mode(paired_wide_mode),
  .upper_timer_ext_clock_pin(upper_timer_ext_clock_pin),
  .count_value(count_value), .timer_active(timer_active)
);
`default_nettype wire

/* File: dv/tb.sv */
// self-checking bench for the upper timer control block
// apb master tasks, read notes queued and checked by a monitor
`timescale 1ns/10ps
`default_nettype none

module tb;
  import tcu_pkg::*;
  localparam logic [11:0] CT = TCU_CTRL_OFFSET;
  localparam logic [11:0] CN = TCU_COUNT_OFFSET;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        idle_mode = 0, paired_wide_mode = 0, pin = 0, err;
  logic        pready, pslverr, timer_active;
  logic [11:0] paddr = 0;
  logic [3:0]  pstrb = 4'hF;
  logic [31:0] pwdata = 0, prdata, rng = 51, qe, qt, r;
  logic [15:0] count_value;
  logic [31:0] eq[$], tq[$];
  int          failures = 0, check_count = 0;
  int          dv[4] = '{1, 8, 64, 256};

  tcu_upper_timer i_tcu_upper_timer (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .idle_mode(idle_mode),
    .paired_wide_mode(paired_wide_mode), .upper_timer_ext_clock_pin(pin),
    .count_value(count_value), .timer_active(timer_active)
  );

  always #2 pclk = ~pclk;

  function logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  task chk(input logic ok, input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (ok !== 1'b1) begin
      failures++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask

  task end_of_test();
    if (failures == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task tk(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // waits for pready however late; only the watchdog ends a hang
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask

  task rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] t);
    eq.push_back(e);
    tq.push_back(t);
    apb(1'b0, a, 32'h0000_0000);
  endtask

  // reads are judged against the oldest note, within its tolerance
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready === 1'b1) begin
      qe = eq.pop_front();
      qt = tq.pop_front();
      chk((prdata - qe) <= qt, "prdata", qe, prdata);
    end
  end

  initial begin
    tk(20);
    presetn <= 1;
    rd(CT, 0, 0);
    rd(CN, 0, 0);
    apb(1, CT, 32'h0000_FFFF);
    rd(CT, 32'h0000_A072, 0);
    rd(12'h0FC, 0, 0);
    chk(err, "pslverr", 1, {31'h0, err});
    apb(1, CT, 0);
    r = xs() & 32'h0000_FFFF;
    apb(1, CN, r);
    tk(50);
    rd(CN, r, 0);
    chk(count_value == r[15:0], "count_value", r, {16'h0, count_value});
    // lane one only: high byte cleared, low byte kept
    pstrb <= 4'h2;
    apb(1, CN, 32'h0000_0000);
    pstrb <= 4'hF;
    rd(CN, {24'h00_0000, r[7:0]}, 0);
    chk(count_value == {8'h00, r[7:0]}, "count_value", r[7:0], {16'h0, count_value});
    for (int p = 0; p < 4; p++) begin
      apb(1, CN, 0);
      apb(1, CT, 32'h0000_8000 | (p << 4));
      tk(510);
      apb(1, CT, 0);
      rd(CN, 32'(512 / dv[p] - 2), 3);
    end
    idle_mode <= 1;
    apb(1, CN, 0);
    apb(1, CT, 32'h0000_A000);
    tk(1);
    chk(!timer_active, "active", 0, {31'h0, timer_active});
    tk(50);
    rd(CN, 0, 0);
    apb(1, CT, 32'h0000_8000);
    tk(1);
    chk(timer_active, "active", 1, {31'h0, timer_active});
    idle_mode <= 0;
    paired_wide_mode <= 1;
    apb(1, CT, 32'h0000_8000);
    apb(1, CN, 0);
    tk(1);
    chk(!timer_active, "active", 0, {31'h0, timer_active});
    tk(50);
    rd(CN, 0, 0);
    rd(TCU_STAT_OFFSET, 32'(1 << TCU_ST_PAIR_BIT), 0);
    paired_wide_mode <= 0;
    // eleven rises, ten falls: only rising edges give eleven
    for (int g = 0; g < 2; g++) begin
      apb(1, CT, 0);
      apb(1, CN, 0);
      apb(1, CT, 32'h0000_8002 | (g << 6));
      for (int i = 0; i < 10; i++) begin
        pin <= 1;
        tk(4 + xs() % 4);
        pin <= 0;
        tk(4 + xs() % 4);
      end
      pin <= 1;
      tk(12);
      apb(1, CT, 0);
      rd(CN, 11, 0);
      pin <= 0;
    end
    apb(1, CN, 0);
    apb(1, CT, 32'h0000_8040);
    tk(100);
    rd(CN, 0, 0);
    pin <= 1;
    tk(200);
    pin <= 0;
    tk(10);
    apb(1, CT, 0);
    rd(CN, 195, 10);
    // second reset with the timer stopped: registers back to zero
    presetn <= 0;
    tk(3);
    presetn <= 1;
    rd(CT, 0, 0);
    rd(CN, 0, 0);
    tk(5);
    end_of_test();
  end

  initial begin
    #80000;
    failures++;
    end_of_test();
  end
endmodule
`default_nettype wire
